// [rtl/cci_timing_top.sv]
/*
  Control channel watchdog, remote write guard and I2C pin timing:
  glitch filter, SDA input hold, SDA output delay and ACK setup,
  bus-idle watchdog with nine-clock recovery.
  Assumes an I2C engine beside it on core_clk and a link on link_clk.
*/
`timescale 1ns/1ps
`include "cci_defines.svh"
module cci_timing_top
  import cci_pkg::*;
#(
  parameter int unsigned TMO_UNIT_CYC = `CCI_TMO_UNIT_NS / `CCI_CLK_NS,
  parameter int unsigned BUS_SLOW_CYC = `CCI_BUS_SLOW_NS / `CCI_CLK_NS,
  parameter int unsigned BUS_FAST_CYC = `CCI_BUS_FAST_NS / `CCI_CLK_NS
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       link_clk,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic       reg_remote,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  output logic            reg_wr_refused,
  input  wire logic       link_txn_start,
  input  wire logic       link_txn_done,
  output logic            link_txn_abort,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_oe,
  output logic            sda_oe,
  output logic            scl_flt,
  output logic            sda_held,
  input  wire logic       tx_sda_low,
  input  wire logic       tx_ack_phase,
  input  wire logic       remote_active,
  output logic            bus_free,
  output logic            bus_recovering
);
  localparam int unsigned REC_HALF_CYC = `CCI_REC_HALF_NS / `CCI_CLK_NS;

  logic [7:0] wd_cfg, ctl1, ctl2, next_wd_cfg, next_ctl1, next_ctl2;
  logic [7:0] next_rdata;
  logic       next_refused;
  logic       wr_block;
  logic       blocked;

  // register port; a refused write leaves the registers untouched
  always_comb begin
    next_wd_cfg  = wd_cfg;
    next_ctl1    = ctl1;
    next_ctl2    = ctl2;
    next_rdata   = reg_rdata;
    wr_block     = ctl1[`CCI_BLOCK_BIT];
    blocked      = reg_wr && reg_remote && wr_block;
    next_refused = blocked;
    if (reg_wr && !blocked) begin
      case (reg_addr)
        `CCI_ADDR_WD:   next_wd_cfg = reg_wdata;
        `CCI_ADDR_CTL1: next_ctl1   = reg_wdata;
        `CCI_ADDR_CTL2: next_ctl2   = reg_wdata;
        default:        next_wd_cfg = wd_cfg;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `CCI_ADDR_WD:   next_rdata = wd_cfg;
        `CCI_ADDR_CTL1: next_rdata = ctl1;
        `CCI_ADDR_CTL2: next_rdata = ctl2;
        default:        next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cfg         <= `CCI_WD_RST;
      ctl1           <= `CCI_CTL1_RST;
      ctl2           <= `CCI_CTL2_RST;
      reg_rdata      <= 8'h00;
      reg_wr_refused <= 1'b0;
    end else begin
      wd_cfg         <= next_wd_cfg;
      ctl1           <= next_ctl1;
      ctl2           <= next_ctl2;
      reg_rdata      <= next_rdata;
      reg_wr_refused <= next_refused;
    end
  end

  // link domain: events leave as toggles, the abort comes back as one
  logic start_tgl, done_tgl, next_start_tgl, next_done_tgl;
  logic abt_s1, abt_s2, abt_s3, abort_tgl;
  always_comb begin
    next_start_tgl = start_tgl ^ link_txn_start;
    next_done_tgl  = done_tgl ^ link_txn_done;
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_tgl <= 1'b0;
      done_tgl  <= 1'b0;
      abt_s1    <= 1'b0;
      abt_s2    <= 1'b0;
      abt_s3    <= 1'b0;
    end else begin
      start_tgl <= next_start_tgl;
      done_tgl  <= next_done_tgl;
      abt_s1    <= abort_tgl;
      abt_s2    <= abt_s1;
      abt_s3    <= abt_s2;
    end
  end
  // a stopped link clock delays the abort pulse until it runs again
  assign link_txn_abort = abt_s2 ^ abt_s3;

  // core domain: transaction watchdog in units of the prescaler
  logic        st_s1, st_s2, st_s3, dn_s1, dn_s2, dn_s3;
  logic        txn_active, next_active, next_abort_tgl;
  logic [18:0] pre_cnt, next_pre_cnt;
  logic [6:0]  unit_cnt, next_unit_cnt;
  logic        unit_tick, abort_now, tmo_off;
  logic [6:0]  tmo_val;

  always_comb begin
    tmo_off        = wd_cfg[`CCI_TMO_OFF_BIT];
    tmo_val        = wd_cfg[`CCI_TMO_MSB:`CCI_TMO_LSB];
    unit_tick      = (pre_cnt == 19'(TMO_UNIT_CYC - 1));
    next_pre_cnt   = unit_tick ? 19'h00000 : pre_cnt + 19'h00001;
    next_unit_cnt  = unit_tick ? unit_cnt + 7'h01 : unit_cnt;
    abort_now      = txn_active && !tmo_off && unit_tick &&
                     (unit_cnt + 7'h01 == tmo_val);
    next_active    = txn_active;
    if ((dn_s2 ^ dn_s3) || abort_now) begin
      next_active = 1'b0;
    end
    if (st_s2 ^ st_s3) begin
      next_active = 1'b1;
    end
    if (!next_active || tmo_off || (st_s2 ^ st_s3)) begin
      next_pre_cnt  = 19'h00000;
      next_unit_cnt = 7'h00;
    end
    next_abort_tgl = abort_tgl ^ abort_now;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {st_s1, st_s2, st_s3} <= 3'h0;
      {dn_s1, dn_s2, dn_s3} <= 3'h0;
      txn_active <= 1'b0;
      pre_cnt    <= 19'h00000;
      unit_cnt   <= 7'h00;
      abort_tgl  <= 1'b0;
    end else begin
      {st_s1, st_s2, st_s3} <= {start_tgl, st_s1, st_s2};
      {dn_s1, dn_s2, dn_s3} <= {done_tgl, dn_s1, dn_s2};
      txn_active <= next_active;
      pre_cnt    <= next_pre_cnt;
      unit_cnt   <= next_unit_cnt;
      abort_tgl  <= next_abort_tgl;
    end
  end

  // pin inputs: synchronised and filtered
  logic [4:0] filt_cyc;
  logic       sda_flt;
  assign filt_cyc = 5'((32'(ctl1[`CCI_FILT_MSB:`CCI_FILT_LSB]) *
                        `CCI_FILT_UNIT_NS + `CCI_CLK_NS - 1) / `CCI_CLK_NS);

  cci_glitch_filter u_scl_flt (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .pin_in    (scl_in),
    .depth_cyc (filt_cyc),
    .flt_out   (scl_flt)
  );

  cci_glitch_filter u_sda_flt (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .pin_in    (sda_in),
    .depth_cyc (filt_cyc),
    .flt_out   (sda_flt)
  );

  // input hold, output delay after SCL fall and ACK setup stretch
  logic [6:0]  hold_cyc, hold_cnt, next_hold_cnt;
  logic        next_held, scl_q, next_scl_q, sda_q, next_sda_q;
  logic [6:0]  dly_cyc, dly_cnt, next_dly_cnt;
  logic        dly_busy, next_dly_busy, sda_pend, next_sda_pend;
  logic        sda_drive, next_sda_drive;
  logic [11:0] setup_cyc, stretch_cnt, next_stretch_cnt;
  logic        stretch, next_stretch;
  logic        scl_fall;

  always_comb begin
    hold_cyc  = 7'((32'(ctl1[`CCI_HOLD_MSB:`CCI_HOLD_LSB]) *
                    `CCI_HOLD_UNIT_NS + `CCI_CLK_NS - 1) / `CCI_CLK_NS);
    dly_cyc   = 7'((`CCI_DLY_BASE_NS + 32'(ctl2[`CCI_DLY_MSB:`CCI_DLY_LSB])
                    * `CCI_DLY_UNIT_NS + `CCI_CLK_NS - 1) / `CCI_CLK_NS);
    setup_cyc = 12'((`CCI_SETUP_BASE_NS +
                     32'(ctl2[`CCI_SETUP_MSB:`CCI_SETUP_LSB]) *
                     `CCI_SETUP_UNIT_NS + `CCI_CLK_NS - 1) / `CCI_CLK_NS);
    scl_fall  = scl_q && !scl_flt;
    next_scl_q = scl_flt;
    next_sda_q = sda_flt;
    // SDA seen by the engine lags the pin by the hold time
    next_held     = sda_held;
    next_hold_cnt = 7'h00;
    if (sda_flt != sda_held) begin
      if (hold_cnt >= hold_cyc) begin
        next_held = sda_flt;
      end else begin
        next_hold_cnt = hold_cnt + 7'h01;
      end
    end
    next_sda_pend    = sda_pend;
    next_dly_busy    = dly_busy;
    next_dly_cnt     = dly_cnt;
    next_sda_drive   = sda_drive;
    next_stretch     = stretch;
    next_stretch_cnt = stretch_cnt;
    if (scl_fall) begin
      next_sda_pend = tx_sda_low;
      next_dly_busy = 1'b1;
      next_dly_cnt  = 7'h01;
    end else if (dly_busy) begin
      if (dly_cnt >= dly_cyc) begin
        next_dly_busy  = 1'b0;
        next_sda_drive = sda_pend;
        if (tx_ack_phase && remote_active) begin
          next_stretch     = 1'b1;
          next_stretch_cnt = 12'h001;
        end
      end else begin
        next_dly_cnt = dly_cnt + 7'h01;
      end
    end
    if (stretch && !(dly_busy && dly_cnt >= dly_cyc)) begin
      if (stretch_cnt >= setup_cyc) begin
        next_stretch = 1'b0;
      end else begin
        next_stretch_cnt = stretch_cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_held    <= 1'b1;
      hold_cnt    <= 7'h00;
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
      sda_pend    <= 1'b0;
      dly_busy    <= 1'b0;
      dly_cnt     <= 7'h00;
      sda_drive   <= 1'b0;
      stretch     <= 1'b0;
      stretch_cnt <= 12'h000;
    end else begin
      sda_held    <= next_held;
      hold_cnt    <= next_hold_cnt;
      scl_q       <= next_scl_q;
      sda_q       <= next_sda_q;
      sda_pend    <= next_sda_pend;
      dly_busy    <= next_dly_busy;
      dly_cnt     <= next_dly_cnt;
      sda_drive   <= next_sda_drive;
      stretch     <= next_stretch;
      stretch_cnt <= next_stretch_cnt;
    end
  end

  // bus-idle watchdog and nine-pulse recovery
  cci_rec_type rec_state, next_rec_state;
  logic [27:0] idle_cnt, next_idle_cnt, idle_lim;
  logic [10:0] half_cnt, next_half_cnt;
  logic [3:0]  pulse_cnt, next_pulse_cnt;
  logic        next_free, activity, expire, bus_off;

  always_comb begin
    bus_off  = ctl2[`CCI_BUS_OFF_BIT];
    idle_lim = ctl2[`CCI_FAST_BIT] ? 28'(BUS_FAST_CYC - 1)
                                   : 28'(BUS_SLOW_CYC - 1);
    activity = (scl_q != scl_flt) || (sda_q != sda_flt);
    expire   = (rec_state == rec_idle) && !bus_off && !activity &&
               (idle_cnt == idle_lim);
    next_idle_cnt  = expire ? idle_cnt : idle_cnt + 28'h0000001;
    next_free      = bus_free && !activity;
    next_rec_state = rec_state;
    next_half_cnt  = half_cnt + 11'h001;
    next_pulse_cnt = pulse_cnt;
    if (expire && sda_flt) begin
      next_free = 1'b1;
    end
    if (activity || bus_off || rec_state != rec_idle) begin
      next_idle_cnt = 28'h0000000;
    end
    case (rec_state)
      rec_idle: begin
        next_half_cnt  = 11'h000;
        next_pulse_cnt = 4'h0;
        if (expire && !sda_flt) begin
          next_rec_state = rec_low;
        end
      end
      rec_low: begin
        if (half_cnt == 11'(REC_HALF_CYC - 1)) begin
          next_half_cnt  = 11'h000;
          next_rec_state = rec_high;
        end
      end
      rec_high: begin
        if (half_cnt == 11'(REC_HALF_CYC - 1)) begin
          next_half_cnt = 11'h000;
          if (pulse_cnt == 4'(`CCI_REC_PULSES - 1)) begin
            next_rec_state = rec_idle;
          end else begin
            next_pulse_cnt = pulse_cnt + 4'h1;
            next_rec_state = rec_low;
          end
        end
      end
      default: next_rec_state = rec_idle;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_state <= rec_idle;
      idle_cnt  <= 28'h0000000;
      half_cnt  <= 11'h000;
      pulse_cnt <= 4'h0;
      bus_free  <= 1'b0;
    end else begin
      rec_state <= next_rec_state;
      idle_cnt  <= next_idle_cnt;
      half_cnt  <= next_half_cnt;
      pulse_cnt <= next_pulse_cnt;
      bus_free  <= next_free;
    end
  end

  // open-drain drives: recovery owns SCL and releases SDA
  assign bus_recovering = (rec_state != rec_idle);
  assign scl_oe = (rec_state == rec_low) || (stretch && !bus_recovering);
  assign sda_oe = sda_drive && !bus_recovering;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_remote_blocked_wd;
    reg_wr && reg_remote && wr_block && reg_addr == `CCI_ADDR_WD;
  endsequence
  property p_refuse_remote;
    s_remote_blocked_wd |=> $stable(wd_cfg) && reg_wr_refused;
  endproperty
  a_refuse_remote: assert property (p_refuse_remote)
    else $error("blocked remote write changed a register");

  property p_local_write;
    reg_wr && !reg_remote && reg_addr == `CCI_ADDR_CTL1 |=>
      ctl1 == $past(reg_wdata) && !reg_wr_refused;
  endproperty
  a_local_write: assert property (p_local_write)
    else $error("unblocked write not stored");

  property p_abort_timeout;
    txn_active && !tmo_off && unit_tick && !(st_s2 ^ st_s3) &&
      unit_cnt + 7'h01 == tmo_val |=>
      !txn_active && abort_tgl != $past(abort_tgl);
  endproperty
  a_abort_timeout: assert property (p_abort_timeout)
    else $error("timeout did not abort the transaction");

  property p_off_no_abort;
    tmo_off |=> unit_cnt == 7'h00 && $stable(abort_tgl);
  endproperty
  a_off_no_abort: assert property (p_off_no_abort)
    else $error("watchdog ran while switched off");

  property p_bus_free;
    $rose(bus_free) |->
      $past(sda_flt) && $past(!bus_off) && $past(idle_cnt == idle_lim);
  endproperty
  a_bus_free: assert property (p_bus_free)
    else $error("bus marked free without a quiet interval");

  sequence s_stuck_expire;
    expire && !sda_flt;
  endsequence
  property p_recover_start;
    s_stuck_expire |=> rec_state == rec_low && scl_oe && !sda_oe;
  endproperty
  a_recover_start: assert property (p_recover_start)
    else $error("stuck SDA did not start recovery");

  property p_nine_pulses;
    $fell(bus_recovering) |-> $past(pulse_cnt) == 4'(`CCI_REC_PULSES - 1);
  endproperty
  a_nine_pulses: assert property (p_nine_pulses)
    else $error("recovery ended after the wrong pulse count");

  property p_activity_restart;
    activity |=> idle_cnt == 28'h0000000 && !bus_free;
  endproperty
  a_activity_restart: assert property (p_activity_restart)
    else $error("bus activity did not restart the idle count");

  property p_timer_off;
    bus_off |=> (idle_cnt == 28'h0000000 && !bus_recovering) ||
                $past(bus_recovering);
  endproperty
  a_timer_off: assert property (p_timer_off)
    else $error("bus watchdog counted while off");

  sequence s_ack_apply;
    dly_busy && dly_cnt >= dly_cyc && tx_ack_phase && remote_active &&
      !scl_fall;
  endsequence
  property p_ack_setup;
    s_ack_apply |=> stretch [*8];
  endproperty
  a_ack_setup: assert property (p_ack_setup)
    else $error("ACK setup stretch too short");

  property p_out_delay;
    scl_fall |=> $stable(sda_drive) [*8];
  endproperty
  a_out_delay: assert property (p_out_delay)
    else $error("SDA output changed too soon after SCL fall");
endmodule : cci_timing_top

// [pkg/cci_defines.svh]
/*
  Constants of the control channel I2C timing block: register offsets,
  field positions, reset values and timing figures.
  Assumes a 250 MHz core clock; included by its bare name.
*/
`ifndef CCI_DEFINES_SVH
`define CCI_DEFINES_SVH

// register offsets
`define CCI_ADDR_WD        8'h08
`define CCI_ADDR_CTL1      8'h09
`define CCI_ADDR_CTL2      8'h0A

// reset values
`define CCI_WD_RST         8'hFE
`define CCI_CTL1_RST       8'h1E
`define CCI_CTL2_RST       8'h10

// field positions
`define CCI_TMO_MSB        7
`define CCI_TMO_LSB        1
`define CCI_TMO_OFF_BIT    0
`define CCI_BLOCK_BIT      7
`define CCI_HOLD_MSB       6
`define CCI_HOLD_LSB       4
`define CCI_FILT_MSB       3
`define CCI_FILT_LSB       0
`define CCI_SETUP_MSB      7
`define CCI_SETUP_LSB      4
`define CCI_DLY_MSB        3
`define CCI_DLY_LSB        2
`define CCI_FAST_BIT       1
`define CCI_BUS_OFF_BIT    0

// timing figures in nanoseconds; CCI_REC_PULSES is a pulse count
`define CCI_CLK_NS         4
`define CCI_TMO_UNIT_NS    2000000
`define CCI_HOLD_UNIT_NS   50
`define CCI_FILT_UNIT_NS   5
`define CCI_SETUP_BASE_NS  80
`define CCI_SETUP_UNIT_NS  640
`define CCI_DLY_BASE_NS    240
`define CCI_DLY_UNIT_NS    40
`define CCI_BUS_SLOW_NS    1000000000
`define CCI_BUS_FAST_NS    50000
`define CCI_REC_HALF_NS    5000
`define CCI_REC_PULSES     9

`endif

// [pkg/cci_pkg.sv]
/*
  Types of the control channel I2C timing block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cci_pkg;
  // bus recovery sequencer
  typedef enum logic [1:0] {
    rec_idle,
    rec_low,
    rec_high
  } cci_rec_type;
endpackage : cci_pkg

// [rtl/cci_glitch_filter.sv]
/*
  Two-flop synchroniser and glitch filter for one I2C input pin.
  Assumes the pin is asynchronous to core_clk and idles high.
*/
`timescale 1ns/1ps
module cci_glitch_filter (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       pin_in,
  input  wire logic [4:0] depth_cyc,
  output logic            flt_out
);
  logic       sync1;
  logic       sync2;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic       next_flt;

  // a new level is taken only after it outlasts the reject width
  always_comb begin
    next_cnt = 5'h00;
    next_flt = flt_out;
    if (sync2 != flt_out) begin
      if (cnt >= depth_cyc) begin
        next_flt = sync2;
      end else begin
        next_cnt = cnt + 5'h01;
      end
    end
  end

  // sync1 feeds sync2 only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1   <= 1'b1;
      sync2   <= 1'b1;
      cnt     <= 5'h00;
      flt_out <= 1'b1;
    end else begin
      sync1   <= pin_in;
      sync2   <= sync1;
      cnt     <= next_cnt;
      flt_out <= next_flt;
    end
  end
endmodule : cci_glitch_filter

// [test/cci_far_side.sv]
/*
  Far side model: pulled-up I2C wires, a target that can hang SDA low,
  and the link end that opens and closes control channel transactions.
  Assumes open-drain enables from the device and a free-running link_clk.
*/
`timescale 1ns/1ps
module cci_far_side (
  input  wire logic link_clk,
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  input  wire logic ctl_scl_low,
  input  wire logic ctl_sda_low,
  input  wire logic stuck_en,
  output logic      scl_in,
  output logic      sda_in,
  output logic      link_txn_start,
  output logic      link_txn_done
);
  logic stuck_hold  = 1'b0;
  logic stuck_armed = 1'b0;
  int   rises       = 0;

  // wired-and with pull-ups: a released line reads high
  assign scl_in = !(scl_oe || ctl_scl_low);
  assign sda_in = !(sda_oe || ctl_sda_low || stuck_hold);

  // target caught mid-byte: holds SDA low until clocked out; one
  // process owns the hold so that it has a single driver
  always @(posedge stuck_en or posedge scl_in) begin
    if (stuck_en && !stuck_armed) begin
      stuck_armed = 1'b1;
      stuck_hold = 1'b1;
      rises = 0;
    end else if (stuck_hold) begin
      rises = rises + 1;
      if (rises == 9) stuck_hold = 1'b0;
    end
    if (!stuck_en) stuck_armed = 1'b0;
  end

  initial begin
    link_txn_start = 1'b0;
    link_txn_done = 1'b0;
  end

  // one link_clk pulse, launched just after an edge
  task automatic link_pulse(input bit is_done);
    @(posedge link_clk);
    #1;
    if (is_done) link_txn_done = 1'b1;
    else link_txn_start = 1'b1;
    @(posedge link_clk);
    #1;
    link_txn_start = 1'b0;
    link_txn_done = 1'b0;
  endtask : link_pulse
endmodule : cci_far_side

// [test/cci_timing_top_tb_top.sv]
/*
  Self-checking bench: registers, write guard, link watchdog, bus
  watchdog and recovery, filter, hold, output delay and ACK setup.
  Assumes the far side model; counts are shortened by parameters.
*/
`timescale 1ns/1ps
module cci_timing_top_tb_top
  import cci_pkg::*;
;
  localparam int UNIT = 50;
  localparam int SLOW = 400;
  localparam int FAST = 100;
  logic       core_clk = 0;
  logic       link_clk = 0;
  logic       rst_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       reg_wr, reg_rd, reg_remote, reg_wr_refused;
  logic       link_txn_start, link_txn_done, link_txn_abort;
  logic       scl_in, sda_in, scl_oe, sda_oe, scl_flt, sda_held;
  logic       tx_sda_low, tx_ack_phase, remote_active;
  logic       bus_free, bus_recovering;
  logic       ctl_scl_low, ctl_sda_low, stuck_en;
  logic [7:0] r;
  int         fails = 0;
  int         n_checks = 0;
  int         n_abort = 0;
  int         n, n1;
  realtime    t0, t_abort;

  // two unrelated clocks: 4 ns core, 6 ns link
  always #2 core_clk = ~core_clk;
  always #3 link_clk = ~link_clk;

  // abort is one link cycle wide; sample it mid-cycle, away from edges
  always @(negedge link_clk) begin
    if (link_txn_abort === 1'b1) begin
      n_abort++;
      t_abort = $realtime;
    end
  end

  cci_timing_top #(
    .TMO_UNIT_CYC(UNIT),
    .BUS_SLOW_CYC(SLOW),
    .BUS_FAST_CYC(FAST)
  ) dut (
    .core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_remote(reg_remote), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_wr_refused(reg_wr_refused),
    .link_txn_start(link_txn_start), .link_txn_done(link_txn_done),
    .link_txn_abort(link_txn_abort), .scl_in(scl_in), .sda_in(sda_in),
    .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_flt(scl_flt),
    .sda_held(sda_held), .tx_sda_low(tx_sda_low),
    .tx_ack_phase(tx_ack_phase), .remote_active(remote_active),
    .bus_free(bus_free), .bus_recovering(bus_recovering)
  );

  cci_far_side far (
    .link_clk(link_clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .ctl_scl_low(ctl_scl_low), .ctl_sda_low(ctl_sda_low),
    .stuck_en(stuck_en), .scl_in(scl_in), .sda_in(sda_in),
    .link_txn_start(link_txn_start), .link_txn_done(link_txn_done)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic chkr(input int v, input int lo, input int hi);
    chk({7'h00, (v >= lo && v <= hi)}, 8'h01);
  endtask : chkr

  // every task leaves the bench just after a core edge
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic wait_for(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_for

  // refused pulse stands one cycle, so capture it before moving on
  task automatic wr(input logic [7:0] a, d, input logic rem);
    reg_addr = a;
    reg_wdata = d;
    reg_remote = rem;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    reg_remote = 1'b0;
    r = reg_wr_refused;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic rem);
    reg_addr = a;
    reg_remote = rem;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    reg_remote = 1'b0;
    r = reg_rdata;
    cyc(1);
  endtask : rd

  task automatic bump(input int k);
    ctl_scl_low = 1'b1;
    cyc(k);
    ctl_scl_low = 1'b0;
  endtask : bump

  task automatic t_regs();
    rd(8'h08, 0); chk(r, 8'hFE);
    rd(8'h09, 0); chk(r, 8'h1E);
    rd(8'h0A, 0); chk(r, 8'h10);
    rd(8'h0B, 0); chk(r, 8'h00);
    wr(8'h0A, 8'h11, 0);
    wr(8'h09, 8'h9E, 0); chk(r, 8'h00);
    wr(8'h08, 8'h06, 1); chk(r, 8'h01);
    rd(8'h08, 0); chk(r, 8'hFE);
    rd(8'h09, 1); chk(r, 8'h9E);
    wr(8'h08, 8'h06, 0); chk(r, 8'h00);
    wr(8'h09, 8'h1E, 0);
    wr(8'h08, 8'h04, 1); chk(r, 8'h00);
    rd(8'h08, 0); chk(r, 8'h04);
    $display("done registers");
  endtask : t_regs

  // field is 2 (never 0), so abort lands 2 units after start
  task automatic t_link();
    t0 = $realtime;
    far.link_pulse(0);
    n = 0;
    while (n_abort == 0 && n < 200) begin
      cyc(1);
      n++;
    end
    chk(n_abort[7:0], 8'h01);
    chkr(int'(t_abort - t0), 2 * UNIT * 4, 2 * UNIT * 4 + 70);
    far.link_pulse(0);
    cyc(60);
    far.link_pulse(1);
    cyc(150);
    chk(n_abort[7:0], 8'h01);
    wr(8'h08, 8'h05, 0);
    far.link_pulse(0);
    cyc(250);
    chk(n_abort[7:0], 8'h01);
    far.link_pulse(1);
    cyc(1);
    $display("done link watchdog");
  endtask : t_link

  task automatic t_bus();
    wr(8'h0A, 8'h10, 0);
    bump(30);
    cyc(300);
    chk(bus_free, 1'b0);
    bump(30);
    wait_for(bus_free, 1'b1, 1000);
    chkr(n, SLOW, SLOW + 40);
    wr(8'h0A, 8'h12, 0);
    bump(30);
    chk(bus_free, 1'b0);
    wait_for(bus_free, 1'b1, 1000);
    chkr(n, FAST, FAST + 40);
    wr(8'h0A, 8'h11, 0);
    bump(30);
    cyc(600);
    chk(bus_free, 1'b0);
    // hung target: nine pulses on SCL must free it
    wr(8'h0A, 8'h10, 0);
    stuck_en = 1'b1;
    wait_for(bus_recovering, 1'b1, 600);
    chk(bus_recovering, 1'b1);
    n1 = 0;
    r[0] = 1'b0;
    for (int i = 0; i < 25000 && bus_recovering === 1'b1; i++) begin
      if (scl_oe === 1'b1 && !r[0]) n1++;
      r[0] = scl_oe;
      cyc(1);
    end
    chk(n1[7:0], 8'h09);
    chk(sda_in, 1'b1);
    stuck_en = 1'b0;
    wr(8'h0A, 8'h11, 0);
    $display("done bus watchdog");
  endtask : t_bus

  task automatic t_pins();
    r[1] = 1'b1;
    bump(10);
    repeat (40) begin
      r[1] = r[1] & scl_flt;
      cyc(1);
    end
    chk(r[1], 1'b1);
    ctl_scl_low = 1'b1;
    cyc(30);
    chk(scl_flt, 1'b0);
    ctl_scl_low = 1'b0;
    cyc(40);
    for (int d = 0; d < 4; d++) begin
      wr(8'h0A, {4'h1, 2'(d), 2'b01}, 0);
      tx_sda_low = 1'b1;
      ctl_scl_low = 1'b1;
      wait_for(scl_flt, 1'b0, 40);
      wait_for(sda_oe, 1'b1, 200);
      chkr(n, 59 + 10 * d, 62 + 10 * d);
      ctl_scl_low = 1'b0;
      tx_sda_low = 1'b0;
      cyc(30);
      bump(30);
      cyc(120);
      chk(sda_oe, 1'b0);
    end
    $display("done filter and delay");
  endtask : t_pins

  task automatic t_ack();
    wr(8'h0A, 8'h11, 0);
    tx_ack_phase = 1'b1;
    remote_active = 1'b1;
    // controller holds SCL low past the output delay, as on a real bus
    ctl_scl_low = 1'b1;
    wait_for(scl_oe, 1'b1, 200);
    ctl_scl_low = 1'b0;
    wait_for(scl_oe, 1'b0, 400);
    chkr(n, 178, 182);
    remote_active = 1'b0;
    r[2] = 1'b0;
    bump(30);
    repeat (300) begin
      r[2] = r[2] | scl_oe;
      cyc(1);
    end
    chk(r[2], 1'b0);
    tx_ack_phase = 1'b0;
    for (int h = 1; h < 4; h += 2) begin
      wr(8'h09, {1'b0, 3'(h), 4'h2}, 0);
      ctl_sda_low = 1'b1;
      wait_for(sda_held, 1'b0, 100);
      if (h == 1) n1 = n;
      ctl_sda_low = 1'b0;
      cyc(60);
    end
    chkr(n - n1, 24, 26);
    $display("done ack setup and hold");
  endtask : t_ack

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // hang guard, about three times the expected run
  initial begin
    #300000;
    fails++;
    print_verdict();
  end

  initial begin
    rst_n = 0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    {reg_wr, reg_rd, reg_remote, tx_sda_low} = 4'h0;
    {tx_ack_phase, remote_active, ctl_scl_low} = 3'h0;
    {ctl_sda_low, stuck_en} = 2'h0;
    repeat (2) @(posedge link_clk);
    @(posedge core_clk);
    #1;
    rst_n = 1;
    t_regs();
    t_link();
    t_bus();
    t_pins();
    t_ack();
    print_verdict();
  end
endmodule : cci_timing_top_tb_top
